/* File: verilog/rot_params.svh */
// constants for the remote output terminal block
`ifndef ROT_PARAMS_SVH
`define ROT_PARAMS_SVH
`define ROT_WORD_W 12
`define ROT_NUM_TERM 18
`define ROT_CODE_W 8
`define ROT_CODE_POS 8'h60
`define ROT_CODE_NEG 8'hC4
`define ROT_RETAIN_RST 1'h0
`define ROT_WORD_RST 12'h000
// terminal bit positions inside {word two, word one}
`define ROT_POS_DOA 5'h00
`define ROT_POS_DOB 5'h01
`define ROT_POS_DOC 5'h02
`define ROT_POS_RELAY 5'h05
`define ROT_POS_EXTA 5'h08
`define ROT_POS_EXTB 5'h09
`define ROT_POS_EXTC 5'h0A
`define ROT_POS_OPT0 5'h0C
`define ROT_POS_RLY1 5'h13
`define ROT_POS_NETRLY 5'h16
`endif

/* File: verilog/rot_pkg.sv */
// types for the remote output terminal block
`include "rot_params.svh"
package rot_pkg;
  typedef enum logic [1:0] {
    SEL_RETAIN,
    SEL_WORD_ONE,
    SEL_WORD_TWO
  } rot_sel_t;
  typedef struct packed {
    logic valid;
    rot_sel_t sel;
    logic [`ROT_WORD_W-1:0] data;
  } rot_wr_t;
  typedef logic [`ROT_NUM_TERM-1:0][`ROT_CODE_W-1:0] rot_fsel_t;
  typedef struct packed {
    logic retain;
    logic [`ROT_WORD_W-1:0] wordOne;
    logic [`ROT_WORD_W-1:0] wordTwo;
    logic [`ROT_WORD_W-1:0] saveOne;
    logic [`ROT_WORD_W-1:0] saveTwo;
    logic [`ROT_NUM_TERM-1:0] term;
  } rot_state_t;
endpackage

/* File: verilog/rot_remote_out.sv */
// remote output terminal block: data words, retention store and terminal drive
`timescale 1ns/100ps
`include "rot_params.svh"
// How it works
// R1: a set data bit turns a terminal on under the positive remote code, off under the negative.
// R2: a clear data bit turns a terminal off under the positive code, on under the negative.
// R3: with retention 0 a power failure clears both words, so terminals show the zero-bit level.
// R4: with retention 1 a power failure saves both words and recovery restores them.
// R5: a drive reset never saves the words; only a power failure does.
// R6: terminals not assigned remote output follow their own function and ignore the data bits.
// R7: both words are writable from the panel, the panel connector link and the option.
// R8: a drive reset zeroes the words, or loads the saved values when retention is 1.
// R9: changing retention from 1 to 0 clears the saved words.
// R10: word one drives the three base outputs, the relay contact and three extension outputs.
// R11: word two drives seven option outputs, three option relays and a network relay.
// R12: extension and option terminals drive nothing when their option is absent.
// R13: a terminal follows a word write one cycle after the word updates, glitch free.
module rot_remote_out (
  input wire logic mclk,
  input wire logic resetn,
  input wire rot_pkg::rot_wr_t operatorPanelWr,
  input wire rot_pkg::rot_wr_t panelConnectorLinkWr,
  input wire rot_pkg::rot_wr_t optionWr,
  input wire logic powerFail,
  input wire logic powerRecover,
  input wire logic driveReset,
  input wire rot_pkg::rot_fsel_t terminalFunctionSelect,
  input wire logic [`ROT_NUM_TERM-1:0] functionLevel,
  input wire logic extensionFitted,
  input wire logic optionOutFitted,
  input wire logic optionRelayFitted,
  input wire logic networkRelayFitted,
  output logic [`ROT_NUM_TERM-1:0] terminalOut,
  output logic retainRd,
  output logic [`ROT_WORD_W-1:0] wordOneRd,
  output logic [`ROT_WORD_W-1:0] wordTwoRd
);

  // ---------------------------------------------------------------
  // terminal map
  // ---------------------------------------------------------------
  // position of terminal i inside {word two, word one}
  function automatic logic [4:0] termPos(input int i);
    logic [4:0] p;
    p = 5'h00;
    if (i < 3) begin
      p = `ROT_POS_DOA + 5'(i);
    end else if (i == 3) begin
      p = `ROT_POS_RELAY;
    end else if (i < 7) begin
      p = `ROT_POS_EXTA + 5'(i - 4);
    end else if (i < 14) begin
      p = `ROT_POS_OPT0 + 5'(i - 7);
    end else if (i < 17) begin
      p = `ROT_POS_RLY1 + 5'(i - 14);
    end else begin
      p = `ROT_POS_NETRLY;
    end
    return p;
  endfunction

  // is the hardware behind terminal i present
  function automatic logic termFitted(input int i, input logic [3:0] fit);
    logic f;
    f = 1'b1;
    if (i >= 4 && i < 7) begin
      f = fit[0];
    end else if (i >= 7 && i < 14) begin
      f = fit[1];
    end else if (i >= 14 && i < 17) begin
      f = fit[2];
    end else if (i == 17) begin
      f = fit[3];
    end
    return f;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rot_pkg::rot_state_t st_reg;
  rot_pkg::rot_state_t st_next;
  rot_pkg::rot_wr_t wr;
  logic [2*`ROT_WORD_W-1:0] dataBits;
  logic [3:0] fitVec;

  // write arbitration, panel first since an operator on site overrides remote masters
  // R7: three write sources
  always_comb begin
    if (operatorPanelWr.valid) begin
      wr = operatorPanelWr;
    end else if (panelConnectorLinkWr.valid) begin
      wr = panelConnectorLinkWr;
    end else begin
      wr = optionWr;
    end
  end

  assign dataBits = {st_reg.wordTwo, st_reg.wordOne};
  assign fitVec = {networkRelayFitted, optionRelayFitted, optionOutFitted, extensionFitted};

  // next state: power failure beats drive reset, which beats writes
  always_comb begin
    logic [`ROT_CODE_W-1:0] code;
    code = '0;
    st_next = st_reg;
    if (powerFail) begin
      if (st_reg.retain) begin
        // R4: save words at power failure
        st_next.saveOne = st_reg.wordOne;
        st_next.saveTwo = st_reg.wordTwo;
      end else begin
        // R3: clear words at power failure
        st_next.wordOne = `ROT_WORD_RST;
        st_next.wordTwo = `ROT_WORD_RST;
      end
    end else if (powerRecover || driveReset) begin
      // R5: no save on drive reset
      // R8: volatile words, restored only under retention
      if (st_reg.retain) begin
        st_next.wordOne = st_reg.saveOne;
        st_next.wordTwo = st_reg.saveTwo;
      end else begin
        st_next.wordOne = `ROT_WORD_RST;
        st_next.wordTwo = `ROT_WORD_RST;
      end
    end else if (wr.valid) begin
      // R10: word one takes the full 0..4095 range
      // R11: word two takes the full 0..4095 range
      if (wr.sel == rot_pkg::SEL_WORD_ONE) begin
        st_next.wordOne = wr.data;
      end else if (wr.sel == rot_pkg::SEL_WORD_TWO) begin
        st_next.wordTwo = wr.data;
      end else if (wr.sel == rot_pkg::SEL_RETAIN) begin
        st_next.retain = wr.data[0];
        // R9: leaving retention drops the saved words
        if (st_reg.retain && !wr.data[0]) begin
          st_next.saveOne = `ROT_WORD_RST;
          st_next.saveTwo = `ROT_WORD_RST;
        end
      end
    end
    // terminals from registered words only, so untouched bits never glitch
    // R13: one cycle behind the word
    for (int i = 0; i < `ROT_NUM_TERM; i++) begin
      code = terminalFunctionSelect[i];
      if (!termFitted(i, fitVec)) begin
        // R12: absent option drives nothing
        st_next.term[i] = 1'b0;
      end else if (code == `ROT_CODE_POS) begin
        // R1: positive polarity
        st_next.term[i] = dataBits[termPos(i)];
      end else if (code == `ROT_CODE_NEG) begin
        // R2: negative polarity
        st_next.term[i] = !dataBits[termPos(i)];
      end else begin
        // R6: own function wins
        st_next.term[i] = functionLevel[i];
      end
    end
  end

  // single state register; resetn is the commissioning reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_reg <= '{retain: `ROT_RETAIN_RST, wordOne: `ROT_WORD_RST, wordTwo: `ROT_WORD_RST,
                 saveOne: `ROT_WORD_RST, saveTwo: `ROT_WORD_RST, term: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign terminalOut = st_reg.term;
  assign retainRd = st_reg.retain;
  assign wordOneRd = st_reg.wordOne;
  assign wordTwoRd = st_reg.wordTwo;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  posPolarity_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    terminalFunctionSelect[0] == `ROT_CODE_POS |=> terminalOut[0] == $past(st_reg.wordOne[0]))
    else $error("positive terminal does not follow its bit");

  negPolarity_a: assert property (@(posedge mclk) disable iff (!resetn) // R2
    terminalFunctionSelect[7] == `ROT_CODE_NEG && optionOutFitted
    |=> terminalOut[7] == !$past(st_reg.wordTwo[0]))
    else $error("negative terminal does not invert its bit");

  failClear_a: assert property (@(posedge mclk) disable iff (!resetn) // R3
    powerFail && !st_reg.retain |=> wordOneRd == 12'h000 && wordTwoRd == 12'h000)
    else $error("words not cleared at power failure");

  failSave_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
    powerFail && st_reg.retain ##1 powerRecover && !powerFail
    |=> wordTwoRd == $past(st_reg.wordTwo, 2))
    else $error("restored word differs from word at failure");

  noResetSave_a: assert property (@(posedge mclk) disable iff (!resetn) // R5
    driveReset && !powerFail && !wr.valid |=> $stable(st_reg.saveOne))
    else $error("drive reset changed the saved word");

  ownFunction_a: assert property (@(posedge mclk) disable iff (!resetn) // R6
    terminalFunctionSelect[2] != `ROT_CODE_POS && terminalFunctionSelect[2] != `ROT_CODE_NEG
    |=> terminalOut[2] == $past(functionLevel[2]))
    else $error("non remote terminal ignored its function");

  linkWrite_a: assert property (@(posedge mclk) disable iff (!resetn) // R7
    !operatorPanelWr.valid && panelConnectorLinkWr.valid && !powerFail && !powerRecover
    && !driveReset && panelConnectorLinkWr.sel == rot_pkg::SEL_WORD_TWO
    |=> wordTwoRd == $past(panelConnectorLinkWr.data))
    else $error("link write lost");

  resetZero_a: assert property (@(posedge mclk) disable iff (!resetn) // R8
    driveReset && !powerFail && !st_reg.retain |=> wordOneRd == 12'h000)
    else $error("drive reset kept a volatile word");

  retainDrop_a: assert property (@(posedge mclk) disable iff (!resetn) // R9
    wr.valid && wr.sel == rot_pkg::SEL_RETAIN && !wr.data[0] && st_reg.retain
    && !powerFail && !powerRecover && !driveReset |=> st_reg.saveTwo == 12'h000)
    else $error("saved words kept after leaving retention");

  absentOption_a: assert property (@(posedge mclk) disable iff (!resetn) // R12
    !extensionFitted |=> terminalOut[4] == 1'b0)
    else $error("absent extension drives a terminal");

  wordToPin_a: assert property (@(posedge mclk) disable iff (!resetn) // R13
    operatorPanelWr.valid && operatorPanelWr.sel == rot_pkg::SEL_WORD_ONE
    && !powerFail && !powerRecover && !driveReset
    ##1 terminalFunctionSelect[0] == `ROT_CODE_POS
    |=> terminalOut[0] == $past(operatorPanelWr.data[0], 2))
    else $error("terminal late after word write");

endmodule

/* File: tb/rot_load_model.sv */
// load model for the loads wired to the output terminals
`timescale 1ns/100ps
`include "rot_params.svh"
module rot_load_model (
  input wire logic [`ROT_NUM_TERM-1:0] terminalOut,
  output logic [`ROT_NUM_TERM-1:0] loadOn
);
  // ---------------
  // load coils
  // ---------------
  // a load is energised only while its terminal drives; it holds no memory of old drive
  assign loadOn = terminalOut;
endmodule

/* File: tb/rot_remote_out_test.sv */
// self-checking bench for the remote output terminal block
`timescale 1ns/100ps
`include "rot_params.svh"
module rot_remote_out_test;
  logic mclk;
  logic resetn;
  rot_pkg::rot_wr_t wrs [3];
  logic [2:0] evt;
  rot_pkg::rot_fsel_t fsel;
  logic [`ROT_NUM_TERM-1:0] fnLevel;
  logic [3:0] fitted;
  logic [`ROT_NUM_TERM-1:0] terminalOut;
  logic [`ROT_NUM_TERM-1:0] loadOn;
  logic retainRd;
  logic [11:0] wordOneRd;
  logic [11:0] wordTwoRd;
  logic [11:0] e1;
  logic [11:0] e2;
  int n_fail;
  int samples_checked;
  // ---------------
  // clock, design, load model
  // ---------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  rot_remote_out dut_u (.mclk(mclk), .resetn(resetn), .operatorPanelWr(wrs[0]),
    .panelConnectorLinkWr(wrs[1]), .optionWr(wrs[2]), .powerFail(evt[2]),
    .powerRecover(evt[1]), .driveReset(evt[0]), .terminalFunctionSelect(fsel),
    .functionLevel(fnLevel), .extensionFitted(fitted[0]), .optionOutFitted(fitted[1]),
    .optionRelayFitted(fitted[2]), .networkRelayFitted(fitted[3]),
    .terminalOut(terminalOut), .retainRd(retainRd), .wordOneRd(wordOneRd),
    .wordTwoRd(wordTwoRd));
  rot_load_model load_u (.terminalOut(terminalOut), .loadOn(loadOn));
  // expected terminals from the words, the function codes and the fitted options
  function automatic logic [`ROT_NUM_TERM-1:0] expt();
    logic [23:0] w;
    logic [4:0] p;
    logic f;
    w = {e2, e1};
    for (int i = 0; i < `ROT_NUM_TERM; i++) begin
      p = (i < 3) ? i[4:0] : (i == 3) ? 5'h05 : (i < 7) ? i[4:0] + 5'h04 : i[4:0] + 5'h05;
      f = (i < 4) | ((i < 7) & fitted[0]) | ((i > 6) & (i < 14) & fitted[1]) |
        ((i > 13) & (i < 17) & fitted[2]) | ((i == 17) & fitted[3]);
      expt[i] = !f ? 1'b0 : (fsel[i] == `ROT_CODE_POS) ? w[p] :
        (fsel[i] == `ROT_CODE_NEG) ? ~w[p] : fnLevel[i];
    end
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_all();
    chk({12'h000, wordOneRd}, {12'h000, e1});
    chk({12'h000, wordTwoRd}, {12'h000, e2});
    chk({6'h00, loadOn}, {6'h00, expt()});
  endtask
  // one write, called at a falling edge; returns once the terminals have followed
  task automatic wr(input int src, input logic [1:0] sel, input logic [11:0] d);
    wrs[src] = '{1'b1, rot_pkg::rot_sel_t'(sel), d};
    @(negedge mclk);
    // drop every source, so a loser held alongside is not taken on the next edge
    for (int k = 0; k < 3; k++) begin
      wrs[k].valid = 1'b0;
    end
    if (sel == 2'h1) e1 = d;
    if (sel == 2'h2) e2 = d;
    @(negedge mclk);
  endtask
  // one-cycle event pulse: fail, recover, drive reset
  task automatic ev(input logic [2:0] e);
    evt = e;
    @(negedge mclk);
    evt = 3'h0;
    @(negedge mclk);
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ---------------
  // tests
  // ---------------
  initial begin
    resetn = 1'b0;
    evt = 3'h0;
    for (int i = 0; i < 3; i++) wrs[i] = '0;
    for (int i = 0; i < `ROT_NUM_TERM; i++) fsel[i] = `ROT_CODE_POS;
    fsel[1] = `ROT_CODE_NEG;
    fsel[2] = 8'h00;
    fsel[7] = `ROT_CODE_NEG;
    fsel[9] = `ROT_CODE_NEG;
    fnLevel = 18'h00004;
    fitted = 4'hF;
    e1 = 12'h000;
    e2 = 12'h000;
    n_fail = 0;
    samples_checked = 0;
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    chk({23'h0, retainRd}, 24'h0);
    chk_all();
    wr(0, 2'h1, 12'hFFF);
    chk_all();
    wr(1, 2'h1, 12'h000);
    chk_all();
    wr(2, 2'h2, 12'hA5A);
    chk_all();
    wr(0, 2'h3, 12'h123);
    chk_all();
    // panel and option on the same edge: panel wins, the option write is lost
    wrs[2] = '{1'b1, rot_pkg::SEL_WORD_ONE, 12'h0F0};
    wr(0, 2'h1, 12'h707);
    chk_all();
    // retention on: save at failure, restore at recovery and drive reset
    wr(0, 2'h0, 12'h001);
    chk({23'h0, retainRd}, 24'h1);
    wr(0, 2'h1, 12'h525);
    wr(1, 2'h2, 12'h3C3);
    ev(3'h4);
    chk_all();
    wr(0, 2'h1, 12'h111);
    wr(0, 2'h2, 12'h222);
    ev(3'h2);
    e1 = 12'h525;
    e2 = 12'h3C3;
    chk_all();
    wr(0, 2'h1, 12'h0FF);
    ev(3'h1);
    e1 = 12'h525;
    chk_all();
    // failure directly followed by recovery brings back the word just written
    wr(0, 2'h2, 12'h2D2);
    evt = 3'h4;
    @(negedge mclk);
    ev(3'h2);
    chk_all();
    // retention 1 to 0 wipes the saved words
    wr(0, 2'h0, 12'h000);
    wr(0, 2'h0, 12'h001);
    ev(3'h1);
    e1 = 12'h000;
    e2 = 12'h000;
    chk_all();
    // retention off: failure clears the words, drive reset and recovery zero them
    wr(0, 2'h0, 12'h000);
    wr(1, 2'h1, 12'hFFF);
    wr(2, 2'h2, 12'h7FF);
    ev(3'h4);
    e1 = 12'h000;
    e2 = 12'h000;
    chk_all();
    wr(0, 2'h1, 12'h3A5);
    ev(3'h1);
    e1 = 12'h000;
    chk_all();
    wr(0, 2'h2, 12'h5A5);
    ev(3'h2);
    e2 = 12'h000;
    chk_all();
    // absent options drive nothing; non-remote terminal follows its function
    fitted = 4'h0;
    fnLevel = 18'h00000;
    wr(0, 2'h2, 12'hFFF);
    chk_all();
    fitted = 4'h5;
    wr(0, 2'h1, 12'hFFF);
    chk_all();
    conclude();
  end
  // hang guard, far beyond the 72 cycles the tests take
  initial begin
    #(20 * 3000);
    n_fail++;
    conclude();
  end
endmodule
